// >>> core/timer_regs.svh
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// register indices; byte address is four times the index
`define CTRL_IDX 8'h88
`define MODE_IDX 8'h89
`define A_LOW_IDX 8'h8a
`define B_LOW_IDX 8'h8b
`define A_HIGH_IDX 8'h8c
`define B_HIGH_IDX 8'h8d
`define SPEED_IDX 8'h8e

// control register bit positions
`define CTRL_B_FLAG 7
`define CTRL_B_RUN 6
`define CTRL_A_FLAG 5
`define CTRL_A_RUN 4

// mode register: one nibble per unit
`define MODE_A_LSB 0
`define MODE_B_LSB 4

// speed register bit positions
`define SPEED_A_BIT 3
`define SPEED_B_BIT 4

// reset values
`define RESET_BYTE 8'h00
`define RESET_BIT 1'b0

// prescaler divide ratios, in system clocks per count
`define DIV_SLOW 12
`define DIV_FAST 4

`endif

// >>> core/timer_pkg.sv
package timer_pkg;

  typedef enum logic [1:0] {
    MODE_13,
    MODE_16,
    MODE_RELOAD,
    MODE_SPLIT
  } mode_t;

  // one nibble of the mode register
  typedef struct packed {
    logic gate;
    logic ext;
    mode_t mode;
  } unit_cfg_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } count_t;

  typedef struct packed {
    count_t c;
    logic ovf;
  } step_t;

endpackage

// >>> core/dual_timer.sv
// Function
// - 13-bit count: high byte plus low five
// - 13-bit: low bit four falling bumps high
// - 13-bit wrap to zero sets flag
// - count only when run and gate allows, except split high byte: no gate
// - source: prescaled clock or count pin falls
// - 16-bit wrap to zero sets flag
// - reload mode: low counts, high holds reload
// - low wrap sets flag, reloads from high
// - only unit b drives baud tick
// - unit b split mode freezes its count
// - unit a split: low byte keeps a controls
// - split low byte: prescaled or pin edges
// - split high byte: prescaled, b run, b flag
// - unit b in split: no run, no flag
// - unit b stays baud source meanwhile
// - four count bytes readable, writable, reset zero
// - speed select: twelfth or quarter clock
// - two-bit mode field selects four modes
// - isr entry clears flag, software sets/clears
// - run clear halts and keeps count
`timescale 1ns/1ns
`include "timer_regs.svh"

module dual_timer
  import timer_pkg::*;
#(
  parameter int DIV_SLOW = `DIV_SLOW,
  parameter int DIV_FAST = `DIV_FAST
)
(
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // external pins
  input wire logic unit_a_gate_pin_i,
  input wire logic unit_b_gate_pin_i,
  input wire logic unit_a_count_pin_i,
  input wire logic unit_b_count_pin_i,
  // interrupt service entry
  input wire logic unit_a_isr_enter_i,
  input wire logic unit_b_isr_enter_i,
  // status
  output logic unit_a_overflow_flag_o,
  output logic unit_b_overflow_flag_o,
  output logic baud_tick_o
);

  if (DIV_FAST < 1 || DIV_SLOW > 16 || DIV_SLOW < DIV_FAST ||
      (DIV_SLOW % DIV_FAST) != 0)
  begin : bad_div
    $error("prescaler ratios unusable");
  end

  localparam logic [3:0] SLOW_LAST = 4'(DIV_SLOW - 1);
  localparam logic [3:0] FAST_DIV = 4'(DIV_FAST);
  localparam logic [3:0] FAST_LAST = 4'(DIV_FAST - 1);

  // one count step of a unit in its mode
  function automatic step_t step(input mode_t mode, input count_t c);
    step_t s;
    s.c = c;
    s.ovf = 1'b0;
    case (mode)
      MODE_13:
      begin
        // upper three low bits are left as they are
        s.c.lo[4:0] = c.lo[4:0] + 5'h01;
        if (c.lo[4:0] == 5'h1f)
        begin
          s.c.hi = c.hi + 8'h01;
          s.ovf = (c.hi == 8'hff);
        end
      end
      MODE_16:
      begin
        s.c = count_t'(c + 16'h0001);
        s.ovf = (c == 16'hffff);
      end
      MODE_RELOAD:
      begin
        if (c.lo == 8'hff)
        begin
          s.c.lo = c.hi;
          s.ovf = 1'b1;
        end
        else
        begin
          s.c.lo = c.lo + 8'h01;
        end
      end
      default:
      begin
        s.c.lo = c.lo + 8'h01;
        s.ovf = (c.lo == 8'hff);
      end
    endcase
    return s;
  endfunction

  // count source of one byte counter
  function automatic logic pick_tick(input logic ext,
    input logic fast, input logic fall,
    input logic t_slow, input logic t_fast);
    if (ext)
    begin
      return fall;
    end
    return fast ? t_fast : t_slow;
  endfunction

  logic [3:0] pre_cnt;
  logic t_slow;
  logic t_fast;
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] pin_prev;
  logic [1:0] pin_fall;
  logic [7:0] mode_reg;
  logic run_a;
  logic run_b;
  logic flag_a;
  logic flag_b;
  logic speed_a;
  logic speed_b;
  count_t cnt_a;
  count_t cnt_b;
  unit_cfg_t cfg_a;
  unit_cfg_t cfg_b;
  logic split;
  step_t step_a;
  step_t step_b;
  logic en_a;
  logic en_ah;
  logic en_b;
  logic set_a;
  logic set_b;
  logic ovf_b;
  logic req;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic wr_a_lo;
  logic wr_a_hi;
  logic wr_b_lo;
  logic wr_b_hi;

  // shared prescaler; the fast tick lands on every DIV_FAST-th clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i || t_slow)
    begin
      pre_cnt <= 4'h0;
    end
    else
    begin
      pre_cnt <= pre_cnt + 4'h1;
    end
  end

  assign t_slow = (pre_cnt == SLOW_LAST);
  assign t_fast = ((pre_cnt % FAST_DIV) == FAST_LAST);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_meta <= 2'h3;
      pin_sync <= 2'h3;
      pin_prev <= 2'h3;
    end
    else
    begin
      pin_meta <= {unit_b_count_pin_i, unit_a_count_pin_i};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign pin_fall = pin_prev & ~pin_sync;

  assign cfg_a = unit_cfg_t'(mode_reg[`MODE_A_LSB +: 4]);
  assign cfg_b = unit_cfg_t'(mode_reg[`MODE_B_LSB +: 4]);
  assign split = (cfg_a.mode == MODE_SPLIT);

  assign step_a = step(cfg_a.mode, cnt_a);
  assign step_b = step(cfg_b.mode, cnt_b);

  // low byte keeps unit a controls in split
  assign en_a = run_a && (!cfg_a.gate || unit_a_gate_pin_i) &&
    pick_tick(cfg_a.ext, speed_a, pin_fall[0], t_slow, t_fast);

  // split high byte: prescaled, unit b run bit
  assign en_ah = split && run_b &&
    pick_tick(1'b0, speed_a, 1'b0, t_slow, t_fast);

  // no run bit while unit a is split
  assign en_b = (cfg_b.mode != MODE_SPLIT) && (split || run_b) &&
    (!cfg_b.gate || unit_b_gate_pin_i) &&
    pick_tick(cfg_b.ext, speed_b, pin_fall[1], t_slow, t_fast);

  assign set_a = en_a && step_a.ovf;
  assign ovf_b = en_b && step_b.ovf;

  // in split, high byte owns unit b flag
  // and unit b overflow reaches no flag
  assign set_b = split ? (en_ah && cnt_a.hi == 8'hff) : ovf_b;

  // wishbone decode; one request per ack
  assign req = cyc_i && stb_i && !ack_o;
  assign idx = adr_i[9:2];
  assign wr = req && we_i && sel_i[0];
  assign wbyte = dat_i[7:0];
  assign wr_a_lo = wr && (idx == `A_LOW_IDX);
  assign wr_a_hi = wr && (idx == `A_HIGH_IDX);
  assign wr_b_lo = wr && (idx == `B_LOW_IDX);
  assign wr_b_hi = wr && (idx == `B_HIGH_IDX);

  // read mux, unmapped reads as zero
  always_comb
  begin
    case (idx)
      `CTRL_IDX: rbyte = {flag_b, run_b, flag_a, run_a, 4'h0};
      `MODE_IDX: rbyte = mode_reg;
      `A_LOW_IDX: rbyte = cnt_a.lo;
      `B_LOW_IDX: rbyte = cnt_b.lo;
      `A_HIGH_IDX: rbyte = cnt_a.hi;
      `B_HIGH_IDX: rbyte = cnt_b.hi;
      `SPEED_IDX: rbyte = {3'h0, speed_b, speed_a, 3'h0};
      default: rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= req;
      if (req)
      begin
        dat_o <= {24'h00_0000, rbyte};
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_reg <= `RESET_BYTE;
      run_a <= `RESET_BIT;
      run_b <= `RESET_BIT;
      speed_a <= `RESET_BIT;
      speed_b <= `RESET_BIT;
    end
    else if (wr)
    begin
      case (idx)
        `MODE_IDX: mode_reg <= wbyte;
        `CTRL_IDX:
        begin
          run_a <= wbyte[`CTRL_A_RUN];
          run_b <= wbyte[`CTRL_B_RUN];
        end
        `SPEED_IDX:
        begin
          speed_a <= wbyte[`SPEED_A_BIT];
          speed_b <= wbyte[`SPEED_B_BIT];
        end
        default:
        begin
        end
      endcase
    end
  end

  // flags: a hardware set beats any same-cycle clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag_a <= `RESET_BIT;
      flag_b <= `RESET_BIT;
    end
    else
    begin
      if (wr && idx == `CTRL_IDX)
      begin
        flag_a <= wbyte[`CTRL_A_FLAG];
        flag_b <= wbyte[`CTRL_B_FLAG];
      end
      if (unit_a_isr_enter_i)
      begin
        flag_a <= 1'b0;
      end
      if (unit_b_isr_enter_i)
      begin
        flag_b <= 1'b0;
      end
      if (set_a)
      begin
        flag_a <= 1'b1;
      end
      if (set_b)
      begin
        flag_b <= 1'b1;
      end
    end
  end

  // unit a count; a software write wins over a count step
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_a <= {`RESET_BYTE, `RESET_BYTE};
    end
    else
    begin
      if (en_a)
      begin
        cnt_a <= step_a.c;
      end
      if (en_ah)
      begin
        cnt_a.hi <= cnt_a.hi + 8'h01;
      end
      if (wr_a_lo)
      begin
        cnt_a.lo <= wbyte;
      end
      if (wr_a_hi)
      begin
        cnt_a.hi <= wbyte;
      end
    end
  end

  // unit b count
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_b <= {`RESET_BYTE, `RESET_BYTE};
    end
    else
    begin
      if (en_b)
      begin
        cnt_b <= step_b.c;
      end
      if (wr_b_lo)
      begin
        cnt_b.lo <= wbyte;
      end
      if (wr_b_hi)
      begin
        cnt_b.hi <= wbyte;
      end
    end
  end

  // baud tick from unit b only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      baud_tick_o <= 1'b0;
    end
    else
    begin
      baud_tick_o <= ovf_b;
    end
  end

  assign unit_a_overflow_flag_o = flag_a;
  assign unit_b_overflow_flag_o = flag_b;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence quiet_a;
    !wr_a_lo && !wr_a_hi;
  endsequence

  sequence quiet_b;
    !wr_b_lo && !wr_b_hi;
  endsequence

  sequence bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence

  AST_FREEZE_B: assert property (
    (cfg_b.mode == MODE_SPLIT) and quiet_b |=> $stable(cnt_b))
    else $error("unit b moved while frozen");

  AST_HALT_A: assert property (
    !run_a && !split and quiet_a |=> $stable(cnt_a))
    else $error("unit a moved while halted");

  AST_GATE_A: assert property (
    cfg_a.gate && !unit_a_gate_pin_i && !en_ah and quiet_a
    |=> $stable(cnt_a))
    else $error("unit a counted with gate low");

  AST_RELOAD_A: assert property (
    cfg_a.mode == MODE_RELOAD && cnt_a.lo == 8'hff && en_a
    and quiet_a |=> cnt_a.lo == $past(cnt_a.hi) && flag_a &&
    $stable(cnt_a.hi))
    else $error("reload did not happen");

  AST_WRAP16_A: assert property (
    cfg_a.mode == MODE_16 && cnt_a == 16'hffff && en_a
    and quiet_a |=> cnt_a == 16'h0000 && flag_a)
    else $error("16-bit wrap wrong");

  AST_CARRY13_A: assert property (
    cfg_a.mode == MODE_13 && cnt_a.lo[4:0] == 5'h1f && en_a
    and quiet_a |=> cnt_a.hi == 8'($past(cnt_a.hi) + 8'h01) &&
    cnt_a.lo[4:0] == 5'h00)
    else $error("13-bit carry wrong");

  AST_SPLIT_HI: assert property (
    split && en_ah && cnt_a.hi == 8'hff and quiet_a
    |=> cnt_a.hi == 8'h00 && flag_b)
    else $error("split high byte overflow wrong");

  AST_ACK: assert property (
    bus_req |=> ack_o ##1 !ack_o)
    else $error("wishbone ack timing wrong");

endmodule

// >>> dv/pin_model.sv
`timescale 1ns/1ns
module pin_model
(
  // clock
  input wire logic clk_i,
  // pins toward the timer
  output logic gate_o,
  output logic count_o
);
  initial
  begin
    gate_o = 1'b0;
    count_o = 1'b1;
  end

  task automatic set_gate(input logic v);
    @(posedge clk_i);
    gate_o <= v;
  endtask

  // slow edges, held past the sync delay
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      count_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      count_o <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
  endtask
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ns
`include "timer_regs.svh"
module tb_top
  import timer_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0000_0000;
  logic [31:0] dat_r;
  logic ack;
  logic isr_a = 1'b0;
  logic isr_b = 1'b0;
  logic flag_a, flag_b, baud;
  logic gate_a, cnt_a, gate_b, cnt_b;
  logic [7:0] q, q2;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;

  always #20 clk_i = ~clk_i;

  pin_model pins_a (.clk_i(clk_i), .gate_o(gate_a), .count_o(cnt_a));
  pin_model pins_b (.clk_i(clk_i), .gate_o(gate_b), .count_o(cnt_b));

  dual_timer dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
    .unit_a_gate_pin_i(gate_a), .unit_b_gate_pin_i(gate_b),
    .unit_a_count_pin_i(cnt_a), .unit_b_count_pin_i(cnt_b),
    .unit_a_isr_enter_i(isr_a), .unit_b_isr_enter_i(isr_b),
    .unit_a_overflow_flag_o(flag_a), .unit_b_overflow_flag_o(flag_b),
    .baud_tick_o(baud)
  );

  task automatic end_sim();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a hung handshake lands here; flag waits are bounded
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] seen);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] idx,
                    input logic [7:0] d, output logic [7:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h1;
    dat_w <= {24'h00_0000, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, idx, d, r);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] r);
    wb(1'b0, idx, 8'h00, r);
  endtask

  task automatic t_regs();
    logic [7:0] idx;
    for (int i = 0; i < 4; i++)
    begin
      idx = `A_LOW_IDX + i[7:0];
      rd(idx, q);
      check("count reset", 8'h00, q);
      wr(idx, 8'ha5 ^ idx);
      rd(idx, q);
      check("count rw", 8'ha5 ^ idx, q);
    end
    wr(8'h90, 8'hff);
    rd(8'h90, q);
    check("unmapped", 8'h00, q);
  endtask

  task automatic t_mode16();
    wr(`A_LOW_IDX, 8'hff);
    wr(`A_HIGH_IDX, 8'hff);
    wr(`SPEED_IDX, 8'h08);
    wr(`MODE_IDX, 8'h01);
    wr(`CTRL_IDX, 8'h10);
    repeat (200) if (flag_a !== 1'b1) @(posedge clk_i);
    check("a flag 16", 8'h01, {7'h00, flag_a});
    wr(`CTRL_IDX, 8'h20);
    rd(`A_HIGH_IDX, q);
    check("a high 16", 8'h00, q);
    rd(`A_LOW_IDX, q);
    repeat (40) @(posedge clk_i);
    rd(`A_LOW_IDX, q2);
    check("a halted", q, q2);
    @(posedge clk_i);
    isr_a <= 1'b1;
    @(posedge clk_i);
    isr_a <= 1'b0;
    @(posedge clk_i);
    check("a isr clear", 8'h00, {7'h00, flag_a});
    wr(`CTRL_IDX, 8'h20);
    check("a sw set", 8'h01, {7'h00, flag_a});
    wr(`CTRL_IDX, 8'h00);
    check("a sw clear", 8'h00, {7'h00, flag_a});
  endtask

  task automatic t_mode13();
    wr(`A_LOW_IDX, 8'hff);
    wr(`A_HIGH_IDX, 8'hff);
    wr(`MODE_IDX, 8'h00);
    wr(`CTRL_IDX, 8'h10);
    repeat (200) if (flag_a !== 1'b1) @(posedge clk_i);
    // judge the flag before the halt write, which would set it itself
    check("a flag 13", 8'h01, {7'h00, flag_a});
    wr(`CTRL_IDX, 8'h20);
    rd(`A_HIGH_IDX, q);
    check("a high 13", 8'h00, q);
    rd(`A_LOW_IDX, q);
    check("a low top", 8'h07, {5'h00, q[7:5]});
    wr(`CTRL_IDX, 8'h00);
  endtask

  task automatic t_reload();
    wr(`B_HIGH_IDX, 8'hf0);
    wr(`B_LOW_IDX, 8'hff);
    wr(`SPEED_IDX, 8'h10);
    wr(`MODE_IDX, 8'h20);
    wr(`CTRL_IDX, 8'h40);
    repeat (200) if (baud !== 1'b1) @(posedge clk_i);
    check("baud tick", 8'h01, {7'h00, baud});
    check("b flag", 8'h01, {7'h00, flag_b});
    wr(`CTRL_IDX, 8'h80);
    rd(`B_HIGH_IDX, q);
    check("b reload", 8'hf0, q);
    rd(`B_LOW_IDX, q);
    check("b low top", 8'h0f, {4'h0, q[7:4]});
    wr(`CTRL_IDX, 8'h00);
  endtask

  task automatic t_split();
    wr(`MODE_IDX, 8'h33);
    wr(`A_LOW_IDX, 8'h00);
    wr(`A_HIGH_IDX, 8'hff);
    wr(`B_LOW_IDX, 8'h05);
    wr(`CTRL_IDX, 8'h40);
    repeat (400) if (flag_b !== 1'b1) @(posedge clk_i);
    check("split high flag", 8'h01, {7'h00, flag_b});
    wr(`CTRL_IDX, 8'h00);
    rd(`A_LOW_IDX, q);
    check("split low idle", 8'h00, q);
    rd(`B_LOW_IDX, q);
    check("b frozen", 8'h05, q);
  endtask

  task automatic t_pin();
    wr(`MODE_IDX, 8'h0d);
    wr(`A_LOW_IDX, 8'h00);
    wr(`A_HIGH_IDX, 8'h00);
    wr(`CTRL_IDX, 8'h10);
    pins_a.set_gate(1'b1);
    pins_a.pulse(3);
    pins_a.set_gate(1'b0);
    pins_a.pulse(2);
    rd(`A_LOW_IDX, q);
    // gated edges must not count
    check("pin count", 8'h03, q);
  endtask

  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_mode16();
    t_mode13();
    t_reload();
    t_split();
    t_pin();
    end_sim();
  end
endmodule
